// ==== src/hub_device_config_register.sv ====
// Device configuration register of a four-port hub with its effects
//
// Contract
// - String registers writable only when bit 7 set
// - Serial registers writable only when bit 6 set
// - Bit 5 blocks U1/U2 unless forced accept
// - Forced accept persists until reset or disconnect
// - I2C mode loads bits 5,3,2 from EEPROM
// - SMBus host may overwrite bits 5,3,2
// - Bit 4 reads always one
// - Bit 3 sampled from gang strap
// - Per-port power switching when not ganged
// - Ganged: all ports through first pin
// - Bit 2 sampled from report strap
// - Power status reported only when bit 2 clear
// - Bit 0 reads always zero
`timescale 1ns/1ns
`default_nettype none
`include "hub_cfg_consts.svh"
module hub_device_config_register
    import hub_cfg_pkg::*;
#(
    parameter int PORTS = 4
) (
    input  wire logic             clk_i,          // System clock
    input  wire logic             reset_i,        // Async reset, active high
    input  wire logic             mode_smbus_i,   // 1 SMBus mode, 0 I2C mode
    input  wire logic             gang_strap_pin_i,  // Gang strap level
    input  wire logic             power_report_strap_pin_i, // Report strap
    input  wire reg_wr_s          wr_i,           // Write from serial slave
    input  wire logic             eeprom_load_i,  // Write comes from EEPROM
    input  wire logic [7:0]       rd_addr_i,      // Read address
    output logic [7:0]            rd_data_o,      // Read data (registered)
    input  wire logic [PORTS-1:0] port_pwr_req_i, // Per-port power request
    output logic [PORTS-1:0]      port_power_control_pins_o, // Power pins
    output logic                  pwr_status_en_o, // Status reporting on
    input  wire logic             flpma_i,        // Forced accept seen
    input  wire logic             up_discon_i,    // Upstream disconnect
    output logic                  lpm_en_o,       // U1/U2 allowed
    output logic                  string_write_enable_o, // Strings writable
    output logic                  serial_string_write_enable_o // Serial wr
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic       strap_done_r;
    logic       strap_done_nxt;
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;
    logic       src_ok;
    cfg_fields_s f;

    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v);
        merge = (old_v & ~`DEVCFG_WMASK) | (new_v & `DEVCFG_WMASK);
    endfunction

    // EEPROM only in I2C mode, host only in SMBus mode
    assign src_ok = (eeprom_load_i && !mode_smbus_i)
                 || (!eeprom_load_i && mode_smbus_i);

    always_comb begin
        cfg_nxt = cfg_r;
        strap_done_nxt = 1'b1;
        if (!strap_done_r) begin
            cfg_nxt[`DEVCFG_BIT_GANG] = gang_strap_pin_i;
            cfg_nxt[`DEVCFG_BIT_PRPT_N] = power_report_strap_pin_i;
        end else if (wr_i.wr && wr_i.addr == `DEVCFG_OFFSET && src_ok) begin
            cfg_nxt = merge(cfg_r, wr_i.data);
        end
        cfg_nxt[`DEVCFG_BIT_ONE] = 1'b1;
        cfg_nxt[`DEVCFG_BIT_ZERO] = 1'b0;
    end

    always_comb begin
        rd_nxt = 8'h00;
        if (rd_addr_i == `DEVCFG_OFFSET) begin
            rd_nxt = cfg_r;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_r        <= `DEVCFG_RESET;
            strap_done_r <= 1'b0;
            rd_r         <= 8'h00;
        end else begin
            cfg_r        <= cfg_nxt;
            strap_done_r <= strap_done_nxt;
            rd_r         <= rd_nxt;
        end
    end

    assign rd_data_o = rd_r;

    // ------------------------------------------------------------
    // Field effects
    // ------------------------------------------------------------
    assign f.str_we  = cfg_r[`DEVCFG_BIT_STR_WE];
    assign f.ser_we  = cfg_r[`DEVCFG_BIT_SER_WE];
    assign f.lpm_dis = cfg_r[`DEVCFG_BIT_LPM_DIS];
    assign f.gang    = cfg_r[`DEVCFG_BIT_GANG];
    assign f.prpt_n  = cfg_r[`DEVCFG_BIT_PRPT_N];

    assign string_write_enable_o = f.str_we;
    assign serial_string_write_enable_o = f.ser_we;
    assign pwr_status_en_o = ~f.prpt_n;

    always_comb begin
        port_power_control_pins_o = port_pwr_req_i;
        if (f.gang) begin
            port_power_control_pins_o = '0;
            port_power_control_pins_o[0] = |port_pwr_req_i;
        end
    end

    lpm_gate u_lpm (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .lpm_dis_i   (f.lpm_dis),
        .flpma_i     (flpma_i),
        .up_discon_i (up_discon_i),
        .force_o     (),
        .lpm_en_o    (lpm_en_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    bit_four_one_a: assert property (@(posedge clk_i) disable iff (reset_i)
        cfg_r[`DEVCFG_BIT_ONE] && !cfg_r[`DEVCFG_BIT_ZERO])
        else $error("reserved bits 4/0 wrong");
    bit_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_addr_i == `DEVCFG_OFFSET |=> !rd_data_o[0])
        else $error("bit 0 read as one");
    // Sampled reset keeps the release edge itself out: the flops are
    // still held there, the strap is caught one edge later
    gang_strap_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !strap_done_r && !reset_i
        |=> cfg_r[3] == $past(gang_strap_pin_i))
        else $error("gang strap not captured");
    rpt_strap_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !strap_done_r && !reset_i
        |=> cfg_r[2] == $past(power_report_strap_pin_i))
        else $error("report strap not captured");
    host_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
        strap_done_r && wr_i.wr && wr_i.addr == `DEVCFG_OFFSET
        && mode_smbus_i && !eeprom_load_i
        |=> cfg_r[5:2] == {$past(wr_i.data[5]), 1'b1, $past(wr_i.data[3:2])})
        else $error("host write not taken");
    ee_block_a: assert property (@(posedge clk_i) disable iff (reset_i)
        strap_done_r && mode_smbus_i && eeprom_load_i |=> $stable(cfg_r))
        else $error("EEPROM write in SMBus mode");
    gang_pins_a: assert property (@(posedge clk_i) disable iff (reset_i)
        f.gang |-> port_power_control_pins_o[PORTS-1:1] == '0)
        else $error("ganged mode drives other pins");
    lpm_block_a: assert property (@(posedge clk_i) disable iff (reset_i)
        f.lpm_dis && !u_lpm.force_o |-> !lpm_en_o)
        else $error("U1/U2 allowed while disabled");
    status_a: assert property (@(posedge clk_i) disable iff (reset_i)
        pwr_status_en_o == !cfg_r[2])
        else $error("status reporting mismatch");
endmodule
`default_nettype wire

// ==== src/hub_cfg_consts.svh ====
// Offsets, field positions, reset values of the device configuration register
`ifndef HUB_CFG_CONSTS_SVH
`define HUB_CFG_CONSTS_SVH
`define DEVCFG_OFFSET      8'h05
`define DEVCFG_BIT_STR_WE  3'd7
`define DEVCFG_BIT_SER_WE  3'd6
`define DEVCFG_BIT_LPM_DIS 3'd5
`define DEVCFG_BIT_ONE     3'd4
`define DEVCFG_BIT_GANG    3'd3
`define DEVCFG_BIT_PRPT_N  3'd2
`define DEVCFG_BIT_RSVD1   3'd1
`define DEVCFG_BIT_ZERO    3'd0
`define DEVCFG_RESET       8'h10
`define DEVCFG_WMASK       8'hEE
`endif

// ==== src/hub_cfg_pkg.sv ====
// Types shared by the device configuration register logic
package hub_cfg_pkg;
    typedef enum logic [1:0] {
        CFG_I2C   = 2'h0,
        CFG_SMBUS = 2'h1
    } cfg_mode_e;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_s;

    typedef struct packed {
        logic str_we;
        logic ser_we;
        logic lpm_dis;
        logic gang;
        logic prpt_n;
    } cfg_fields_s;
endpackage

// ==== src/lpm_gate.sv ====
// Gating of U1/U2 entry by the disable bit and the forced-accept latch
`timescale 1ns/1ns
`default_nettype none
module lpm_gate (
    input  wire logic clk_i,        // System clock
    input  wire logic reset_i,      // Async reset, active high
    input  wire logic lpm_dis_i,    // Low-power disable bit
    input  wire logic flpma_i,      // Forced-accept message sent or received
    input  wire logic up_discon_i,  // Upstream port disconnected
    output logic      force_o,      // Forced-accept latch
    output logic      lpm_en_o      // U1/U2 may be initiated/accepted
);
    logic force_r;
    logic force_nxt;

    always_comb begin
        force_nxt = force_r;
        if (flpma_i) begin
            force_nxt = 1'b1;
        end else if (up_discon_i) begin
            force_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            force_r <= 1'b0;
        end else begin
            force_r <= force_nxt;
        end
    end

    assign force_o = force_r;
    assign lpm_en_o = ~lpm_dis_i | force_r;

    force_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        force_r && !up_discon_i |=> force_r)
        else $error("forced accept latch dropped");
endmodule
`default_nettype wire

// ==== verification/cfg_host_model.sv ====
// Behavioural SMBus host and EEPROM loader issuing register writes
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model
    import hub_cfg_pkg::*;
(
    input  wire logic clk_i,        // System clock
    output var reg_wr_s wr_o,       // Write towards the register
    output logic      eeprom_load_o // 1 = write comes from EEPROM
);
    initial begin
        wr_o = '0;
        eeprom_load_o = 1'b0;
    end
    // one-cycle write, bit 1 kept 0
    task automatic send(input logic e, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= '{1'b1, a, d & 8'hFD};
        eeprom_load_o <= e;
        @(posedge clk_i);
        // Released lines show inverted values, never a stale copy
        wr_o <= '{1'b0, ~a, ~d};
        eeprom_load_o <= ~e;
    endtask
endmodule
`default_nettype wire

// ==== verification/test_hub_device_config_register.sv ====
// Self-checking bench for the device configuration register
`timescale 1ns/1ns
`default_nettype none
module test_hub_device_config_register import hub_cfg_pkg::*;;
    logic       clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       mode_i = 1'b1;
    logic       gang_i = 1'b1;
    logic       prpt_i = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [3:0] req = 4'h4;
    logic       flpma = 1'b0;
    logic       discon = 1'b0;
    reg_wr_s    wr;
    logic       eep;
    logic [7:0] rd_data;
    logic [3:0] pins;
    logic       stat_en, lpm_en, str_we, ser_we;
    int         fail_count = 0;
    int         samples_checked = 0;

    hub_device_config_register #(.PORTS(4)) uut (
        .clk_i(clk_i), .reset_i(reset_i), .mode_smbus_i(mode_i),
        .gang_strap_pin_i(gang_i), .power_report_strap_pin_i(prpt_i),
        .wr_i(wr), .eeprom_load_i(eep), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .port_pwr_req_i(req),
        .port_power_control_pins_o(pins), .pwr_status_en_o(stat_en),
        .flpma_i(flpma), .up_discon_i(discon), .lpm_en_o(lpm_en),
        .string_write_enable_o(str_we),
        .serial_string_write_enable_o(ser_we));
    cfg_host_model host (.clk_i(clk_i), .wr_o(wr), .eeprom_load_o(eep));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_addr <= a;
        @(posedge clk_i);
        #1 chk(rd_data, exp);
    endtask

    // Pins, string enable, serial enable, U1/U2 allowed, status on
    task automatic outs(input logic [7:0] exp);
        chk({pins, str_we, ser_we, lpm_en, stat_en}, exp);
    endtask

    task automatic pulse(input logic f, input logic d);
        @(posedge clk_i);
        flpma <= f;
        discon <= d;
        @(posedge clk_i);
        flpma <= 1'b0;
        discon <= 1'b0;
        #1;
    endtask

    task automatic do_reset(input logic g, input logic p);
        @(posedge clk_i);
        reset_i <= 1'b1;
        gang_i <= g;
        prpt_i <= p;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
    endtask

    initial begin
        #20000;
        fail_count++;
        end_sim;
    end

    initial begin
        do_reset(1'b1, 1'b0);
        rd(8'h05, 8'h18);
        outs(8'h13);
        host.send(1'b0, 8'h05, 8'hE5);
        rd(8'h05, 8'hF4);
        outs(8'h4C);
        // Wrong source, then unmapped offset, one idle cycle apart
        host.send(1'b1, 8'h05, 8'h00);
        host.send(1'b0, 8'h06, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h05, 8'hF4);
        pulse(1'b1, 1'b0);
        outs(8'h4E);
        host.send(1'b0, 8'h05, 8'hE5);
        outs(8'h4E);
        pulse(1'b0, 1'b1);
        outs(8'h4C);
        @(posedge clk_i);
        mode_i <= 1'b0;
        host.send(1'b1, 8'h05, 8'h2C);
        rd(8'h05, 8'h3C);
        outs(8'h10);
        host.send(1'b0, 8'h05, 8'h00);
        rd(8'h05, 8'h3C);
        pulse(1'b1, 1'b0);
        do_reset(1'b0, 1'b1);
        rd(8'h05, 8'h14);
        outs(8'h42);
        // Loader sets only bits 7 and 5: forced accept must be gone
        host.send(1'b1, 8'h05, 8'hA0);
        rd(8'h05, 8'hB0);
        outs(8'h49);
        end_sim;
    end
endmodule
`default_nettype wire
